// *** rtl/sdc_pkg.sv ***
`default_nettype none
package sdc_pkg;
   // Register byte offsets on the APB window
   localparam logic [11:0] SDC_CTRL_OFS = 12'h000;
   localparam logic [11:0] SDC_STAT_OFS = 12'h004;
   // Control register field positions
   localparam int COL_HI = 17;
   localparam int COL_LO = 16;
   localparam int SLOW_BIT = 12;
   localparam int REFRESH_ENABLE_BIT = 11;
   localparam int REFRESH_KIND_SELECT_BIT = 10;
   localparam int BANK_BIT = 8;
   localparam logic [1:0] COL_BAD = 2'h3;
   // Status register field positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_ROW = 1;
   localparam int STAT_SELF = 2;
   // Read data capture wait after the read command, pin stage included
   localparam logic [1:0] CAS_WAIT = 2'h3;
   // Command codes as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [12:0] A10_MASK = 13'h0400;

   typedef struct packed {
      logic [1:0] col;
      logic slow;
      logic refresh_enable;
      logic refresh_kind_select;
      logic bank;
   } sdc_cfg_type;

   typedef struct packed {
      logic write;
      logic [22:0] addr;
      logic [15:0] wdata;
   } sdc_req_type;

   typedef struct packed {
      logic cke;
      logic [3:0] cmd;
      logic [12:0] addr;
      logic [15:0] dq;
      logic dq_oe;
   } sdc_pins_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRE = 3'b001,
      ST_ACT = 3'b010,
      ST_RW = 3'b011,
      ST_CAS = 3'b100,
      ST_DONE = 3'b101,
      ST_REF = 3'b110,
      ST_SELF = 3'b111
   } sdc_state_type;

   // Column address width for a column code
   function automatic logic [3:0] col_bits(input logic [1:0] code);
      unique case (code)
         2'h0: col_bits = 4'h8;
         2'h1: col_bits = 4'h9;
         default: col_bits = 4'ha;
      endcase
   endfunction

   // Mask of the column bits for a column code
   function automatic logic [10:0] col_mask(input logic [1:0] code);
      col_mask = 11'((11'h001 << col_bits(code)) - 11'h001);
   endfunction
endpackage
`default_nettype wire

// *** rtl/sdc_ctrl.sv ***
// Overview of operation
// [RL1] The area 2 column code gives 8, 9 or 10 column bits for 00, 01, 10; code 11 is never used.
// [RL2] Control bits 15 to 13 read as zero and software writes zero there.
// [RL3] With the low-frequency bit clear, pins launch and read data is caught on the rising edge.
// [RL4] With the low-frequency bit set, pins launch and read data is caught on the falling edge.
// [RL5] With refresh enable clear no refresh is issued; with it set refresh runs.
// [RL6] Refresh enable and refresh kind both set put the memory into self-refresh at once.
// [RL7] Refresh enable set with refresh kind clear issues auto-refresh paced by the refresh timer.
// [RL8] Control bit 9 reads as zero and software writes zero there.
// [RL9] Auto-precharge mode uses read and write commands with automatic precharge.
// [RL10] Bank active mode keeps the row open and uses plain read and write commands.
// [RL11] Bank mode bit at 1 selects bank active access, at 0 auto-precharge access.
// [RL12] Software picks bank active access only when area 3 alone holds memory.
// [RL13] Software sets all fields once after reset and rewrites them unchanged with refresh bits.
// [RL14] Software does not reach the memory areas before the control register is set.
`timescale 1ns/1ns
`default_nettype none
module sdc_ctrl
   import sdc_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Memory bus clock
   input wire logic sdram_clk,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Access port and refresh timer
   input wire logic acc_valid,
   input wire sdc_pkg::sdc_req_type acc_req,
   output logic acc_ready,
   output logic acc_rvalid,
   output logic [15:0] acc_rdata,
   input wire logic refresh_tick,
   // Memory pins
   output sdc_pkg::sdc_pins_type sdram_pins,
   input wire logic [15:0] dq_in
);
   import sdc_pkg::*;

   sdc_cfg_type cfg_q, cfg_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   sdc_req_type req_q, req_d;
   logic req_tgl_q, req_tgl_d, ref_tgl_q, ref_tgl_d;
   logic acc_ready_q, acc_ready_d, acc_rvalid_q, acc_rvalid_d;
   logic [15:0] acc_rdata_q, acc_rdata_d;
   logic ack_s1_q, ack_s2_q, ack_seen_q;
   logic self_s1_q, self_s2_q, row_s1_q, row_s2_q;
   logic [1:0] lrst_q;
   logic link_rst_n;
   sdc_cfg_type cfg_s1_q, cfg_l;
   logic req_s1_q, req_s2_q, req_seen_q, req_seen_d;
   logic ref_s1_q, ref_s2_q, ref_seen_q;
   sdc_state_type st_q, st_d;
   logic row_open_q, row_open_d, ref_pend_q, ref_pend_d;
   logic [12:0] open_row_q, open_row_d, row_w;
   logic [1:0] cas_q, cas_d;
   logic [15:0] rdata_l_q, rdata_l_d, rd_rise_q, rd_fall_q;
   logic ack_tgl_q, ack_tgl_d, self_q, self_d;
   sdc_pins_type pins_q, pins_d, pins_neg_q;
   logic req_new, self_req;

   // Control word image; reserved bits stay zero
   function automatic logic [31:0] ctrl_word(input sdc_cfg_type c);
      ctrl_word = '0;
      ctrl_word[COL_HI:COL_LO] = c.col;
      ctrl_word[SLOW_BIT] = c.slow;
      ctrl_word[REFRESH_ENABLE_BIT] = c.refresh_enable;
      ctrl_word[REFRESH_KIND_SELECT_BIT] = c.refresh_kind_select;
      ctrl_word[BANK_BIT] = c.bank;
   endfunction

   // APB slave: no wait states, answer in the first access cycle
   always_comb
   begin
      cfg_d = cfg_q;
      pready_d = psel & ~penable;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      if (psel & ~penable)
      begin
         pslverr_d = (paddr != SDC_CTRL_OFS) & (paddr != SDC_STAT_OFS);
         prdata_d = '0;
         if (paddr == SDC_CTRL_OFS)
         begin
            prdata_d = ctrl_word(cfg_q); // RL2 RL8
         end
         else if (paddr == SDC_STAT_OFS)
         begin
            prdata_d[STAT_BUSY] = ~acc_ready_q;
            prdata_d[STAT_ROW] = row_s2_q;
            prdata_d[STAT_SELF] = self_s2_q;
         end
      end
      if (psel & penable & pready_q & pwrite & (paddr == SDC_CTRL_OFS))
      begin
         // The unusable column code is dropped so the decode never sees it
         if (pwdata[COL_HI:COL_LO] != COL_BAD)
         begin
            cfg_d.col = pwdata[COL_HI:COL_LO]; // RL1
         end
         cfg_d.slow = pwdata[SLOW_BIT];
         cfg_d.refresh_enable = pwdata[REFRESH_ENABLE_BIT];
         cfg_d.refresh_kind_select = pwdata[REFRESH_KIND_SELECT_BIT];
         cfg_d.bank = pwdata[BANK_BIT]; // RL11
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else
      begin
         cfg_q <= cfg_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // Core side of the access handshake and refresh tick toggle
   always_comb
   begin
      req_d = req_q;
      req_tgl_d = req_tgl_q;
      acc_ready_d = acc_ready_q;
      acc_rvalid_d = 1'b0;
      acc_rdata_d = acc_rdata_q;
      ref_tgl_d = ref_tgl_q ^ refresh_tick;
      if (acc_valid & acc_ready_q)
      begin
         req_d = acc_req;
         req_tgl_d = ~req_tgl_q;
         acc_ready_d = 1'b0;
      end
      // Link read data is held until the next request, so it is safe here
      if (ack_s2_q != ack_seen_q)
      begin
         acc_rvalid_d = 1'b1;
         acc_rdata_d = rdata_l_q;
         acc_ready_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_q <= '0;
         req_tgl_q <= 1'b0;
         ref_tgl_q <= 1'b0;
         acc_ready_q <= 1'b1;
         acc_rvalid_q <= 1'b0;
         acc_rdata_q <= '0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_seen_q <= 1'b0;
         self_s1_q <= 1'b0;
         self_s2_q <= 1'b0;
         row_s1_q <= 1'b0;
         row_s2_q <= 1'b0;
      end
      else
      begin
         req_q <= req_d;
         req_tgl_q <= req_tgl_d;
         ref_tgl_q <= ref_tgl_d;
         acc_ready_q <= acc_ready_d;
         acc_rvalid_q <= acc_rvalid_d;
         acc_rdata_q <= acc_rdata_d;
         ack_s1_q <= ack_tgl_q;
         ack_s2_q <= ack_s1_q;
         ack_seen_q <= ack_s2_q;
         self_s1_q <= self_q;
         self_s2_q <= self_s1_q;
         row_s1_q <= row_open_q;
         row_s2_q <= row_s1_q;
      end
   end

   // Link reset: asynchronous entry, release aligned to the memory clock
   always_ff @(posedge sdram_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lrst_q <= 2'h0;
      end
      else
      begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign link_rst_n = lrst_q[1];

   // Settings and toggles into the link domain; settings are quasi-static
   always_ff @(posedge sdram_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         cfg_s1_q <= '0;
         cfg_l <= '0;
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
      end
      else
      begin
         cfg_s1_q <= cfg_q;
         cfg_l <= cfg_s1_q;
         req_s1_q <= req_tgl_q;
         req_s2_q <= req_s1_q;
         ref_s1_q <= ref_tgl_q;
         ref_s2_q <= ref_s1_q;
      end
   end

   assign req_new = req_s2_q != req_seen_q;
   assign self_req = cfg_l.refresh_enable & cfg_l.refresh_kind_select;
   assign row_w = 13'(req_q.addr >> col_bits(cfg_l.col)); // RL1

   // Link command sequencer: self-refresh, then refresh, then access
   always_comb
   begin
      st_d = st_q;
      row_open_d = row_open_q;
      open_row_d = open_row_q;
      ref_pend_d = ref_pend_q | (ref_s2_q != ref_seen_q);
      req_seen_d = req_seen_q;
      cas_d = cas_q;
      rdata_l_d = rdata_l_q;
      ack_tgl_d = ack_tgl_q;
      self_d = self_q;
      pins_d = '0;
      pins_d.cke = 1'b1;
      pins_d.cmd = CMD_NOP;
      if (!cfg_l.refresh_enable)
      begin
         ref_pend_d = 1'b0; // RL5
      end
      unique case (st_q)
         ST_IDLE:
         begin
            if (self_req | (ref_pend_q & cfg_l.refresh_enable))
            begin
               st_d = row_open_q ? ST_PRE : (self_req ? ST_SELF : ST_REF); // RL6 RL7
            end
            else if (req_new)
            begin
               if (row_open_q & cfg_l.bank & (open_row_q == row_w))
               begin
                  st_d = ST_RW; // RL10
               end
               else
               begin
                  st_d = row_open_q ? ST_PRE : ST_ACT;
               end
            end
            else if (row_open_q & ~cfg_l.bank)
            begin
               st_d = ST_PRE;
            end
         end
         ST_PRE:
         begin
            pins_d.cmd = CMD_PRE;
            pins_d.addr = A10_MASK;
            row_open_d = 1'b0;
            st_d = ST_IDLE;
         end
         ST_ACT:
         begin
            pins_d.cmd = CMD_ACT;
            pins_d.addr = row_w;
            open_row_d = row_w;
            row_open_d = 1'b1;
            st_d = ST_RW;
         end
         ST_RW:
         begin
            pins_d.cmd = req_q.write ? CMD_WR : CMD_RD;
            pins_d.addr = 13'(req_q.addr[10:0] & col_mask(cfg_l.col)); // RL1
            // Automatic precharge rides on address line 10
            if (!cfg_l.bank)
            begin
               pins_d.addr = pins_d.addr | A10_MASK; // RL9
            end
            row_open_d = cfg_l.bank; // RL10
            pins_d.dq = req_q.wdata;
            pins_d.dq_oe = req_q.write;
            cas_d = '0;
            st_d = req_q.write ? ST_DONE : ST_CAS;
         end
         ST_CAS:
         begin
            cas_d = 2'(cas_q + 2'h1);
            if (cas_q == CAS_WAIT)
            begin
               rdata_l_d = cfg_l.slow ? rd_fall_q : rd_rise_q; // RL3 RL4
               st_d = ST_DONE;
            end
         end
         ST_DONE:
         begin
            req_seen_d = req_s2_q;
            ack_tgl_d = ~ack_tgl_q;
            st_d = ST_IDLE;
         end
         ST_REF:
         begin
            // Refresh switched off in this cycle wins; a tick landing now stays pending
            pins_d.cmd = cfg_l.refresh_enable ? CMD_REF : CMD_NOP; // RL5 RL7
            ref_pend_d = cfg_l.refresh_enable & (ref_s2_q != ref_seen_q);
            st_d = ST_IDLE;
         end
         ST_SELF:
         begin
            // Entry cycle sends refresh with clock enable low, then holds it low
            pins_d.cke = ~self_req;
            pins_d.cmd = (self_q | ~self_req) ? CMD_NOP : CMD_REF; // RL6
            self_d = self_req;
            ref_pend_d = 1'b0;
            if (!self_req)
            begin
               st_d = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sdram_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         st_q <= ST_IDLE;
         row_open_q <= 1'b0;
         open_row_q <= '0;
         ref_pend_q <= 1'b0;
         ref_seen_q <= 1'b0;
         req_seen_q <= 1'b0;
         cas_q <= '0;
         rdata_l_q <= '0;
         ack_tgl_q <= 1'b0;
         self_q <= 1'b0;
         pins_q <= '0;
         rd_rise_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         row_open_q <= row_open_d;
         open_row_q <= open_row_d;
         ref_pend_q <= ref_pend_d;
         ref_seen_q <= ref_s2_q;
         req_seen_q <= req_seen_d;
         cas_q <= cas_d;
         rdata_l_q <= rdata_l_d;
         ack_tgl_q <= ack_tgl_d;
         self_q <= self_d;
         pins_q <= pins_d;
         rd_rise_q <= dq_in; // RL3
      end
   end

   // Falling edge stage: half a cycle later launch and capture for slow parts
   always_ff @(negedge sdram_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         pins_neg_q <= '0;
         rd_fall_q <= '0;
      end
      else
      begin
         pins_neg_q <= pins_q; // RL4
         rd_fall_q <= dq_in; // RL4
      end
   end

   // Edge choice is a flop-to-pin select that follows cfg_l.slow in every state
   assign sdram_pins = cfg_l.slow ? pins_neg_q : pins_q; // RL3 RL4
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign acc_ready = acc_ready_q;
   assign acc_rvalid = acc_rvalid_q;
   assign acc_rdata = acc_rdata_q;

   sequence s_act_then_rw;
      st_q == ST_ACT ##1 st_q == ST_RW;
   endsequence

   a_ctrl_rsv_hi: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
      psel & ~penable & (paddr == SDC_CTRL_OFS) |=> prdata[15:13] == 3'h0)
      else $error("reserved bits 15..13 read nonzero");
   a_ctrl_rsv_9: assert property (@(posedge core_clk) disable iff (!rst_n) // RL8
      pready & ~pslverr & (paddr == SDC_CTRL_OFS) |-> !prdata[9])
      else $error("reserved bit 9 read nonzero");
   a_col_code_kept: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
      psel & penable & pready & pwrite & (paddr == SDC_CTRL_OFS)
      & (pwdata[COL_HI:COL_LO] == COL_BAD) |=> cfg_q.col == $past(cfg_q.col))
      else $error("prohibited column code was stored");
   a_col_width_ok: assert property (@(posedge sdram_clk) disable iff (!link_rst_n) // RL1
      st_q == ST_RW |=> (pins_q.addr[9:0] & ~10'(col_mask(cfg_l.col))) == 10'h000)
      else $error("column address exceeds column width");
   a_no_ref_off: assert property (@(posedge sdram_clk) disable iff (!link_rst_n) // RL5
      !cfg_l.refresh_enable & $past(!cfg_l.refresh_enable) |-> pins_q.cmd != CMD_REF)
      else $error("refresh issued while refresh is off");
   a_self_at_once: assert property (@(posedge sdram_clk) disable iff (!link_rst_n) // RL6
      st_q == ST_IDLE & self_req & !row_open_q |=> st_q == ST_SELF ##1 !pins_q.cke)
      else $error("self-refresh not entered at once");
   a_auto_ref: assert property (@(posedge sdram_clk) disable iff (!link_rst_n) // RL7
      st_q == ST_IDLE & ref_pend_q & cfg_l.refresh_enable & !cfg_l.refresh_kind_select & !row_open_q
      |=> ##1 pins_q.cmd == CMD_REF && pins_q.cke)
      else $error("pending auto-refresh not issued");
   a_autopre_cmd: assert property (@(posedge sdram_clk) disable iff (!link_rst_n) // RL9
      s_act_then_rw ##0 !cfg_l.bank |=> pins_q.addr[10] ##1 !row_open_q)
      else $error("auto-precharge access without precharge flag");
   a_bank_open: assert property (@(posedge sdram_clk) disable iff (!link_rst_n) // RL10
      st_q == ST_RW & cfg_l.bank |=> !pins_q.addr[10] && row_open_q)
      else $error("bank active access closed the row");
   a_slow_launch: assert property (@(negedge sdram_clk) disable iff (!link_rst_n) // RL4
      cfg_l.slow & $past(cfg_l.slow) |-> sdram_pins == $past(pins_q))
      else $error("slow mode launch not half a cycle late");
   a_fast_capture: assert property (@(posedge sdram_clk) disable iff (!link_rst_n) // RL3
      st_q == ST_CAS & cas_q == CAS_WAIT & !cfg_l.slow |=> rdata_l_q == $past(rd_rise_q))
      else $error("fast mode read data not from rising edge");
endmodule
`default_nettype wire

// *** tb/sdc_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module sdc_mem_model
   import sdc_pkg::*;
(
   // Memory clock and pins
   input wire logic sdram_clk,
   input wire sdc_pkg::sdc_pins_type sdram_pins,
   output logic [15:0] dq_in,
   // What the bench inspects
   output logic [12:0] last_row,
   output logic [9:0] last_col,
   output logic last_ap,
   output logic launch_hi,
   output logic [15:0] act_cnt,
   output logic [15:0] ref_cnt,
   output logic [15:0] self_cnt
);
   logic [15:0] mem [logic [22:0]];
   logic [12:0] row_q;
   logic [1:0] lat_q;
   logic [15:0] rd_q;
   logic [22:0] key;

   // Start from a known pattern so a missed capture cannot match by luck
   initial
   begin
      dq_in = 16'h5a5a;
      lat_q = 2'h0;
      act_cnt = 16'h0;
      ref_cnt = 16'h0;
      self_cnt = 16'h0;
   end

   // Clock level at which the command pins last moved
   always @(sdram_pins.cmd)
   begin
      launch_hi = sdram_clk;
   end

   // Commands are taken at the rising edge, as a real memory does
   always @(posedge sdram_clk)
   begin
      key = {row_q, sdram_pins.addr[9:0]};
      if (lat_q != 2'h0)
         lat_q <= lat_q - 2'h1;
      // Outside the data beat the bus toggles, never keeps the last word
      dq_in <= (lat_q != 2'h0) ? rd_q : ~dq_in;
      case (sdram_pins.cmd)
         CMD_ACT:
         begin
            row_q <= sdram_pins.addr;
            act_cnt <= act_cnt + 16'h1;
         end
         CMD_RD, CMD_WR:
         begin
            last_row <= row_q;
            last_col <= sdram_pins.addr[9:0];
            last_ap <= sdram_pins.addr[10];
            if (sdram_pins.cmd == CMD_RD)
            begin
               rd_q <= mem.exists(key) ? mem[key] : 16'h0;
               lat_q <= 2'h2;
            end
            else
               mem[key] = sdram_pins.dq_oe ? sdram_pins.dq : ~sdram_pins.dq;
         end
         CMD_REF:
         begin
            if (sdram_pins.cke)
               ref_cnt <= ref_cnt + 16'h1;
            else
               self_cnt <= self_cnt + 16'h1;
         end
         default:
            key = key;
      endcase
   end
endmodule
`default_nettype wire

// *** tb/sdram_access_refresh_config_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module sdram_access_refresh_config_tb_top;
   import sdc_pkg::*;
   logic core_clk, sdram_clk, rst_n, psel, penable, pwrite, pready, pslverr, re;
   logic acc_valid, acc_ready, acc_rvalid, refresh_tick, last_ap, launch_hi;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [15:0] acc_rdata, dq_in, r16, d, act_cnt, ref_cnt, self_cnt, acts, refs;
   logic [12:0] last_row, row;
   logic [9:0] last_col, col;
   logic [22:0] a;
   sdc_req_type acc_req;
   sdc_pins_type sdram_pins;
   int err_count, check_count, code, slow, bank;

   sdc_ctrl u_sdc_ctrl (.core_clk(core_clk), .rst_n(rst_n), .sdram_clk(sdram_clk),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid),
      .acc_req(acc_req), .acc_ready(acc_ready), .acc_rvalid(acc_rvalid),
      .acc_rdata(acc_rdata), .refresh_tick(refresh_tick), .sdram_pins(sdram_pins),
      .dq_in(dq_in));
   sdc_mem_model u_sdc_mem_model (.sdram_clk(sdram_clk), .sdram_pins(sdram_pins),
      .dq_in(dq_in), .last_row(last_row), .last_col(last_col), .last_ap(last_ap),
      .launch_hi(launch_hi), .act_cnt(act_cnt), .ref_cnt(ref_cnt), .self_cnt(self_cnt));

   // Core clock, 8 ns
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Memory clock, 15 ns, phase unrelated to the core clock
   initial
   begin
      sdram_clk = 1'b0;
      #3;
      forever
      begin
         #7 sdram_clk = 1'b1;
         #8 sdram_clk = 1'b0;
      end
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One access through the access port, waits for completion
   task automatic acc(input logic wr, input logic [22:0] ad, input logic [15:0] wd);
      @(posedge core_clk);
      acc_valid <= 1'b1;
      acc_req <= {wr, ad, wd};
      do @(posedge core_clk); while (acc_ready !== 1'b1);
      acc_valid <= 1'b0;
      do @(posedge core_clk); while (acc_rvalid !== 1'b1);
      r16 = acc_rdata;
   endtask

   task automatic tick();
      @(posedge core_clk);
      refresh_tick <= 1'b1;
      @(posedge core_clk);
      refresh_tick <= 1'b0;
      repeat (40) @(posedge core_clk);
   endtask

   // Bounded wait for the clock enable pin to reach a level
   task automatic wait_cke(input logic lvl);
      repeat (100)
      begin
         @(posedge core_clk);
         if (sdram_pins.cke === lvl)
            break;
      end
      check_val(sdram_pins.cke, lvl);
   endtask

   // Column bits for a column code: 8, 9 or 10
   function automatic logic [9:0] col_mask_of(input int c);
      return 10'((11'h1 << (8 + c)) - 11'h1);
   endfunction

   // Hang guard, well beyond the expected run
   initial
   begin
      repeat (30000) @(posedge core_clk);
      err_count++;
      end_sim();
   end

   initial
   begin
      err_count = 0;
      check_count = 0;
      {psel, penable, pwrite, acc_valid, refresh_tick, rst_n} = '0;
      paddr = 12'h0;
      pwdata = 32'h0;
      acc_req = '0;
      rv = $urandom(32'ha7714079);
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge core_clk);
      apb(0, SDC_CTRL_OFS, 0);
      check_val(rv, 32'h0);
      // All ones: reserved bits stay zero, code 11 refused, self-refresh starts
      apb(1, SDC_CTRL_OFS, 32'hffffffff);
      apb(0, SDC_CTRL_OFS, 0);
      check_val(rv, 32'h00001d00);
      wait_cke(1'b0);
      // The model counts at its own clock edge, a little after the pin moves
      repeat (4) @(posedge core_clk);
      check_val(self_cnt, 1);
      apb(0, SDC_STAT_OFS, 0);
      check_val(rv & 32'h4, 32'h4);
      apb(1, SDC_CTRL_OFS, 32'h00001100);
      wait_cke(1'b1);
      apb(1, SDC_CTRL_OFS, 32'h00020000);
      apb(1, SDC_CTRL_OFS, 32'h00030000);
      apb(0, SDC_CTRL_OFS, 0);
      check_val(rv, 32'h00020000);
      apb(1, 12'h008, 32'hffffffff);
      check_val(re, 1);
      apb(0, 12'h008, 0);
      check_val({re, rv}, {1'b1, 32'h0});
      // Every usable column code, both timing modes, both access modes
      for (int i = 0; i < 12; i++)
      begin
         code = i % 3;
         slow = (i / 3) % 2;
         bank = i / 6;
         apb(1, SDC_CTRL_OFS, (code << COL_LO) | (slow << SLOW_BIT) | (bank << BANK_BIT));
         repeat (4)
         begin
            row = 13'($urandom);
            col = 10'($urandom) & col_mask_of(code);
            d = 16'($urandom);
            a = (23'(row) << (8 + code)) | 23'(col);
            acc(1, a, d);
            acts = act_cnt;
            acc(0, a, 16'h0);
            check_val(r16, d);
            check_val({last_row, last_col}, {row, col});
            check_val(last_ap, !bank);
            check_val(act_cnt - acts, bank ? 0 : 1);
            check_val(launch_hi, !slow);
         end
      end
      // Bank active mode leaves the last row open, nothing busy, no self-refresh
      apb(0, SDC_STAT_OFS, 0);
      check_val(rv, 32'h00000002);
      apb(1, SDC_CTRL_OFS, 0);
      refs = ref_cnt;
      tick();
      check_val(ref_cnt - refs, 0);
      // Auto-refresh, with a closed row and with an open one
      for (int m = 0; m < 2; m++)
      begin
         apb(1, SDC_CTRL_OFS, 32'h00000800 | (m << BANK_BIT));
         d = 16'($urandom);
         acc(1, 23'h1234, d);
         refs = ref_cnt;
         repeat (40) @(posedge core_clk);
         check_val(ref_cnt - refs, 0);
         tick();
         check_val(ref_cnt - refs, 1);
         acc(0, 23'h1234, 16'h0);
         check_val(r16, d);
      end
      end_sim();
   end
endmodule
`default_nettype wire
